// *** tb/fdl_freq_limiter_tb.sv ***
module fdl_freq_limiter_tb
  import fdl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rstn, psel, penable, pwrite, start, jog, heavy, regen_mode;
  logic        cur_over, regen, pready, pslverr, err, overload, fault, fast_en, stall;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] cmd, out_freq;
  int          miscompares, checks;
  logic [7:0]  sels [6] = '{8'h00, 8'h01, SEL_DRIVE_FRL, SEL_DRIVE_NOF,
                            SEL_DRIVE_FRL, SEL_DRIVE_NOF};
  logic        rgs  [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic        fes  [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  logic [7:0]  offs [4] = '{8'h0E, 8'h0F, 8'h1E, 8'h1F};

  fdl_freq_limiter #(.OL_HOLD_CYCLES(8), .TRIP_CYCLES(20)) uut (
    .i_core_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_freq_cmd(cmd), .i_start(start),
    .i_jog(jog), .i_regen(regen), .i_current_over(cur_over), .o_out_freq(out_freq),
    .o_overload(overload), .o_stall_trip_fault(fault), .o_fast_limit_en(fast_en),
    .o_stall_active(stall));
  fdl_stage_model stage (.i_core_clk(clk), .i_heavy(heavy), .i_regen_mode(regen_mode),
    .o_current_over(cur_over), .o_regen(regen));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request held from setup until pready is seen high with psel and penable
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // A slave that never answers ends the run here
    if (n >= 20) begin
      miscompares++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic e);
    xfer(1'b1, a, d);
    chk("pslverr", {31'h0, e}, {31'h0, err});
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    xfer(1'b0, a, 16'h0000);
    chk("pslverr", 32'h0, {31'h0, err});
    chk("prdata", {16'h0000, exp}, rdat);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic run(input logic [15:0] c, input logic s, input logic j, input logic [15:0] exp);
    @(posedge clk);
    cmd <= c;
    start <= s;
    jog <= j;
    cyc(4);
    chk("out_freq", {16'h0000, exp}, {16'h0000, out_freq});
  endtask

  initial begin
    #900000;
    miscompares++;
    finish_test();
  end

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cmd = 16'h0000;
    start = 1'b0;
    jog = 1'b0;
    heavy = 1'b0;
    regen_mode = 1'b0;
    miscompares = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(ADDR_MAX, MAX_RST);
    rd(ADDR_MIN, MIN_RST);
    rd(ADDR_HS_MAX, HS_RST);
    for (int i = 0; i < JUMP_REGS; i++) begin
      rd(ADDR_JUMP_BASE + REG_STRIDE * 8'(i), FREQ_DISABLED);
    end
    wr(ADDR_MAX, 16'h03E8, 1'b0);
    rd(ADDR_HS_MAX, 16'h03E8);
    wr(ADDR_HS_MAX, 16'h07D0, 1'b0);
    rd(ADDR_MAX, 16'h07D0);
    wr(ADDR_MAX, 16'h04B1, 1'b1);
    wr(ADDR_MIN, 16'h04B1, 1'b1);
    wr(ADDR_HS_MAX, 16'h04AF, 1'b1);
    wr(ADDR_JUMP_BASE, 16'h0FA1, 1'b1);
    wr(8'h3C, 16'h0000, 1'b1);
    rd(ADDR_MAX, 16'h07D0);
    wr(ADDR_MAX, 16'h03E8, 1'b0);
    wr(ADDR_ACCEL, FREQ_400HZ, 1'b0);
    run(16'h05DC, 1'b1, 1'b0, 16'h03E8);
    wr(ADDR_MIN, 16'h012C, 1'b0);
    run(16'h0064, 1'b1, 1'b0, 16'h012C);
    run(16'h0000, 1'b1, 1'b0, 16'h012C);
    wr(ADDR_JOG, 16'h0032, 1'b0);
    run(16'h0000, 1'b0, 1'b1, 16'h0032);
    wr(ADDR_JUMP_BASE, 16'h0258, 1'b0);
    wr(ADDR_JUMP_BASE + 8'h04, 16'h01F4, 1'b0);
    wr(ADDR_JUMP_BASE + 8'h08, 16'h02BC, 1'b0);
    wr(ADDR_JUMP_BASE + 8'h0C, 16'h0320, 1'b0);
    wr(ADDR_JUMP_BASE + 8'h10, 16'h044C, 1'b0);
    wr(ADDR_JUMP_BASE + 8'h14, 16'h0384, 1'b0);
    run(16'h0226, 1'b1, 1'b0, 16'h0258);
    run(16'h01F4, 1'b1, 1'b0, 16'h0258);
    run(16'h01F3, 1'b1, 1'b0, 16'h01F3);
    run(16'h0320, 1'b1, 1'b0, 16'h02BC);
    run(16'h03B6, 1'b1, 1'b0, 16'h03E8);
    run(16'h0258, 1'b1, 1'b0, 16'h0258);
    @(posedge clk);
    heavy <= 1'b1;
    cyc(3);
    chk("stall", 32'h1, {31'h0, stall});
    chk("out_freq", 32'h0, {16'h0000, out_freq});
    chk("overload", 32'h1, {31'h0, overload});
    cyc(25);
    chk("fault", 32'h1, {31'h0, fault});
    @(posedge clk);
    heavy <= 1'b0;
    cyc(12);
    chk("overload", 32'h0, {31'h0, overload});
    wr(ADDR_CTRL, 16'h0001, 1'b0);
    cyc(4);
    chk("fault", 32'h0, {31'h0, fault});
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_STALL_SEL, {8'h00, offs[i]}, 1'b0);
      @(posedge clk);
      heavy <= 1'b1;
      cyc(30);
      chk("overload", 32'h0, {31'h0, overload});
      chk("fault", 32'h0, {31'h0, fault});
      @(posedge clk);
      heavy <= 1'b0;
    end
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_STALL_SEL, {8'h00, sels[i]}, 1'b0);
      @(posedge clk);
      regen_mode <= rgs[i];
      cyc(3);
      chk("fast_en", {31'h0, fes[i]}, {31'h0, fast_en});
    end
    // Under selection 101 a heavy load in regeneration gives no overload and no fast limit; stall acts again once driving
    @(posedge clk);
    heavy <= 1'b1;
    cyc(12);
    chk("overload", 32'h0, {31'h0, overload});
    chk("fast_en", 32'h0, {31'h0, fast_en});
    @(posedge clk);
    regen_mode <= 1'b0;
    cyc(3);
    chk("stall", 32'h1, {31'h0, stall});
    finish_test();
  end
endmodule

// *** tb/fdl_stage_model.sv ***
module fdl_stage_model (
  input  wire logic i_core_clk,
  input  wire logic i_heavy,
  input  wire logic i_regen_mode,
  output logic      o_current_over,
  output logic      o_regen
);
  timeunit 1ns;
  timeprecision 1ns;
  // A locked rotor keeps current above the stall level for as long as the load stays on
  always_ff @(posedge i_core_clk) begin
    o_current_over <= i_heavy;
    o_regen        <= i_regen_mode;
  end
endmodule

// *** verilog/fdl_freq_limiter.sv ***
// Behaviour
// - Maximum limit register takes 0 to 120 Hz, resets to 120 Hz.
// - Commands above the maximum limit are clamped to it.
// - Minimum limit register takes 0 to 120 Hz, resets to 0 Hz.
// - Set frequencies below the minimum are raised to the minimum.
// - High-speed maximum takes 120 to 400 Hz, resets to 120 Hz.
// - Writing the high-speed maximum also loads the maximum limit.
// - Writing the maximum limit also loads the high-speed maximum.
// - Jog frequency bypasses the minimum clamp.
// - Stall action may lower output to or below the minimum.
// - With minimum at or above start frequency, start alone ramps to minimum.
// - Three jump zones, endpoints 0 to 400 Hz, 9999 disables.
// - Zone endpoints accepted in either order.
// - Requests inside a zone run at that zone's A endpoint.
// - Selections 14, 15, 30, 31 never give overload or stall fault.
// - Selections 100/101 stall in driving, all off in regeneration.
// - Selection 101 also turns fast-response limit off while driving.
// - Fast-response limit alone never raises overload indication.
// - Selection bits: fast limit off, phase stall off, overload stops run.
// - Overload asserts at least 100 ms, ends when current falls.
// - Stall at 1 Hz or below for 3 s trips output and flags fault.
module fdl_freq_limiter
  import fdl_pkg::*;
#(
  parameter int OL_HOLD_CYCLES = OL_HOLD_CYC,
  parameter int TRIP_CYCLES    = TRIP_CYC
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic [15:0] i_freq_cmd,
  input  wire logic        i_start,
  input  wire logic        i_jog,
  input  wire logic        i_regen,
  input  wire logic        i_current_over,
  output logic      [15:0] o_out_freq,
  output logic             o_overload,
  output logic             o_stall_trip_fault,
  output logic             o_fast_limit_en,
  output logic             o_stall_active
);

  typedef struct packed {
    logic [31:0]                 prdata;
    fdl_freq_t                   max_freq_limit;
    fdl_freq_t                   min_freq_limit;
    fdl_freq_t                   high_speed_max_limit;
    fdl_freq_t                   jog_speed_setting;
    fdl_freq_t                   starting_freq_setting;
    logic [JUMP_REGS-1:0][15:0]  jump;
    logic [7:0]                  stall_select_word;
    fdl_freq_t                   accel_step;
    fdl_freq_t                   out_freq;
    logic                        ol_stop;
    logic                        stall;
  } fdl_state_t;

  fdl_state_t         q_r;
  fdl_state_t         q_nxt;
  logic               setup;
  logic               access;
  logic               wr_ok;
  logic               wr;
  logic               fault_clr;
  logic [31:0]        rd_val;
  logic [2:0][15:0]   zone_a;
  logic [2:0][15:0]   zone_b;
  fdl_freq_t          jz_freq;
  logic               jz_hit;
  fdl_freq_t          tgt;
  fdl_freq_t          cmd;
  fdl_phase_t         phase;
  logic               drive_mode;
  logic               stall_en;
  logic               stall_active;
  logic               overload;
  logic               trip;

  function automatic logic is_jump_addr(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < JUMP_REGS; k++) begin
      if (a == ADDR_JUMP_BASE + 8'(k) * REG_STRIDE) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a == ADDR_MAX) || (a == ADDR_MIN) || (a == ADDR_HS_MAX) || (a == ADDR_JOG)
        || (a == ADDR_START) || is_jump_addr(a) || (a == ADDR_STALL_SEL)
        || (a == ADDR_ACCEL) || (a == ADDR_CTRL) || (a == ADDR_STATUS);
  endfunction

  // Out-of-range values are refused per register; a high-speed maximum write can load up to 400 Hz into the maximum limit
  function automatic logic value_ok(input logic [7:0] a, input logic [31:0] d);
    logic ok;
    if (a == ADDR_MAX || a == ADDR_MIN) begin
      ok = (d <= 32'(FREQ_120HZ));
    end else if (a == ADDR_HS_MAX) begin
      ok = (d >= 32'(FREQ_120HZ)) && (d <= 32'(FREQ_400HZ));
    end else if (is_jump_addr(a)) begin
      ok = (d <= 32'(FREQ_400HZ)) || (d == 32'(FREQ_DISABLED));
    end else if (a == ADDR_JOG || a == ADDR_START) begin
      ok = (d <= 32'(FREQ_400HZ));
    end else if (a == ADDR_ACCEL) begin
      ok = (d != 32'h0000_0000) && (d <= 32'(FREQ_400HZ));
    end else if (a == ADDR_STALL_SEL) begin
      ok = (d <= 32'(SEL_PLAIN_MAX)) || (d == 32'(SEL_DRIVE_FRL))
        || (d == 32'(SEL_DRIVE_NOF));
    end else begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  function automatic fdl_freq_t ramp(input fdl_freq_t cur, input fdl_freq_t dst,
                                     input fdl_freq_t step);
    fdl_freq_t r;
    if (cur < dst) begin
      r = (dst - cur > step) ? cur + step : dst;
    end else if (cur > dst) begin
      r = (cur - dst > step) ? cur - step : dst;
    end else begin
      r = cur;
    end
    return r;
  endfunction

  assign setup     = i_psel & ~i_penable;
  assign access    = i_psel & i_penable;
  assign wr_ok     = mapped(i_paddr) && value_ok(i_paddr, i_pwdata);
  assign wr        = access & i_pwrite & wr_ok;
  assign fault_clr = wr && (i_paddr == ADDR_CTRL) && i_pwdata[CTRL_FAULT_CLR_BIT];

  always_comb begin
    for (int z = 0; z < 3; z++) begin
      zone_a[z] = q_r.jump[2 * z];
      zone_b[z] = q_r.jump[2 * z + 1];
    end
  end

  fdl_jump_zones #(
    .ZONES (3)
  ) u_jump (
    .i_zone_a (zone_a),
    .i_zone_b (zone_b),
    .i_req    (i_freq_cmd),
    .o_freq   (jz_freq),
    .o_hit    (jz_hit)
  );

  always_comb begin
    rd_val = 32'h0000_0000;
    if (i_paddr == ADDR_MAX) begin
      rd_val = 32'(q_r.max_freq_limit);
    end else if (i_paddr == ADDR_MIN) begin
      rd_val = 32'(q_r.min_freq_limit);
    end else if (i_paddr == ADDR_HS_MAX) begin
      rd_val = 32'(q_r.high_speed_max_limit);
    end else if (i_paddr == ADDR_JOG) begin
      rd_val = 32'(q_r.jog_speed_setting);
    end else if (i_paddr == ADDR_START) begin
      rd_val = 32'(q_r.starting_freq_setting);
    end else if (i_paddr == ADDR_STALL_SEL) begin
      rd_val = 32'(q_r.stall_select_word);
    end else if (i_paddr == ADDR_ACCEL) begin
      rd_val = 32'(q_r.accel_step);
    end else if (i_paddr == ADDR_STATUS) begin
      rd_val[15:0]         = q_r.out_freq;
      rd_val[ST_OL_BIT]    = overload;
      rd_val[ST_FAULT_BIT] = trip;
      rd_val[ST_FRL_BIT]   = o_fast_limit_en;
      rd_val[ST_STALL_BIT] = q_r.stall;
      rd_val[ST_STOP_BIT]  = q_r.ol_stop;
    end else begin
      for (int k = 0; k < JUMP_REGS; k++) begin
        if (i_paddr == ADDR_JUMP_BASE + 8'(k) * REG_STRIDE) begin
          rd_val = 32'(q_r.jump[k]);
        end
      end
    end
  end

  // Selection decode: bits 1..3 gate the phases, 100/101 depend on regeneration
  always_comb begin
    drive_mode = (q_r.stall_select_word == SEL_DRIVE_FRL)
              || (q_r.stall_select_word == SEL_DRIVE_NOF);
    if (q_r.out_freq < tgt) begin
      phase = PH_ACCEL;
    end else if (q_r.out_freq == tgt) begin
      phase = PH_CONST;
    end else begin
      phase = PH_DECEL;
    end
    if (drive_mode) begin
      stall_en        = ~i_regen;
      o_fast_limit_en = ~i_regen && (q_r.stall_select_word == SEL_DRIVE_FRL);
    end else begin
      stall_en        = ~q_r.stall_select_word[SEL_BIT_ACC_OFF + int'(phase)];
      o_fast_limit_en = ~q_r.stall_select_word[SEL_BIT_FRL_OFF];
    end
    // Overload comes from stall action only, never from the fast limit
    stall_active = i_current_over & stall_en;
  end

  // Jump first, then clamps; jog skips the minimum
  always_comb begin
    cmd = jz_freq;
    if (cmd > q_r.max_freq_limit) begin
      cmd = q_r.max_freq_limit;
    end
    if (cmd < q_r.min_freq_limit) begin
      cmd = q_r.min_freq_limit;
    end
    if (i_jog) begin
      tgt = (q_r.jog_speed_setting > q_r.max_freq_limit) ? q_r.max_freq_limit
                                                          : q_r.jog_speed_setting;
    end else if (i_start && cmd >= q_r.starting_freq_setting) begin
      tgt = cmd;
    end else begin
      tgt = FREQ_0HZ;
    end
  end

  always_comb begin
    q_nxt = q_r;
    if (setup && !i_pwrite) begin
      q_nxt.prdata = rd_val;
    end
    if (wr) begin
      if (i_paddr == ADDR_MAX || i_paddr == ADDR_HS_MAX) begin
        q_nxt.max_freq_limit       = i_pwdata[15:0];
        q_nxt.high_speed_max_limit = i_pwdata[15:0];
      end else if (i_paddr == ADDR_MIN) begin
        q_nxt.min_freq_limit = i_pwdata[15:0];
      end else if (i_paddr == ADDR_JOG) begin
        q_nxt.jog_speed_setting = i_pwdata[15:0];
      end else if (i_paddr == ADDR_START) begin
        q_nxt.starting_freq_setting = i_pwdata[15:0];
      end else if (i_paddr == ADDR_STALL_SEL) begin
        q_nxt.stall_select_word = i_pwdata[7:0];
      end else if (i_paddr == ADDR_ACCEL) begin
        q_nxt.accel_step = i_pwdata[15:0];
      end
      for (int k = 0; k < JUMP_REGS; k++) begin
        if (i_paddr == ADDR_JUMP_BASE + 8'(k) * REG_STRIDE) begin
          q_nxt.jump[k] = i_pwdata[15:0];
        end
      end
    end
    // Stop latch holds until the run command is dropped; a set wins
    q_nxt.ol_stop = (!drive_mode && q_r.stall_select_word[SEL_BIT_OL_STOP] && overload)
                 || (q_r.ol_stop && (i_start || i_jog));
    q_nxt.stall = stall_active;
    if (trip || q_r.ol_stop) begin
      q_nxt.out_freq = FREQ_0HZ;
    end else if (stall_active) begin
      q_nxt.out_freq = ramp(q_r.out_freq, FREQ_0HZ, q_r.accel_step);
    end else begin
      q_nxt.out_freq = ramp(q_r.out_freq, tgt, q_r.accel_step);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      q_r <= '{prdata: 32'h0000_0000, max_freq_limit: MAX_RST, min_freq_limit: MIN_RST,
               high_speed_max_limit: HS_RST, jog_speed_setting: JOG_RST,
               starting_freq_setting: START_RST, jump: {JUMP_REGS{FREQ_DISABLED}},
               stall_select_word: SEL_RST, accel_step: ACCEL_RST, out_freq: FREQ_0HZ,
               ol_stop: 1'b0, stall: 1'b0};
    end else begin
      q_r <= q_nxt;
    end
  end

  fdl_stall_monitor #(
    .HOLD_CYCLES (OL_HOLD_CYCLES),
    .TRIP_CYCLES (TRIP_CYCLES)
  ) u_stall (
    .i_core_clk     (i_core_clk),
    .i_rstn         (i_rstn),
    .i_stall_active (stall_active),
    .i_low_freq     (q_r.out_freq <= FREQ_1HZ),
    .i_fault_clr    (fault_clr),
    .o_overload     (overload),
    .o_trip         (trip)
  );

  // Zero wait states: read data was captured in the setup cycle
  assign o_pready           = 1'b1;
  assign o_pslverr          = access && (i_pwrite ? !wr_ok : !mapped(i_paddr));
  assign o_prdata           = q_r.prdata;
  assign o_out_freq         = q_r.out_freq;
  assign o_overload         = overload;
  assign o_stall_trip_fault = trip;
  assign o_stall_active     = q_r.stall;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  a_limits_paired: assert property (q_r.max_freq_limit == q_r.high_speed_max_limit)
    else $error("maximum and high-speed maximum differ");
  a_hs_range: assert property (access && i_pwrite && i_paddr == ADDR_HS_MAX
                               && (i_pwdata < 32'(FREQ_120HZ) || i_pwdata > 32'(FREQ_400HZ))
                               |=> $stable(q_r.high_speed_max_limit))
    else $error("high-speed maximum took an out-of-range value");
  a_min_range: assert property (q_r.min_freq_limit <= FREQ_120HZ)
    else $error("minimum limit out of range");
  a_max_clamp: assert property (!i_jog && q_r.out_freq <= q_r.max_freq_limit && !wr
                                |=> q_r.out_freq <= q_r.max_freq_limit)
    else $error("output rose above maximum limit");
  a_min_clamp: assert property (i_start && !i_jog && !stall_active && !trip && !q_r.ol_stop
                                && q_r.min_freq_limit >= q_r.starting_freq_setting
                                && q_r.out_freq >= q_r.min_freq_limit && !wr
                                |=> q_r.out_freq >= q_r.min_freq_limit)
    else $error("output fell below minimum from command path");
  a_jog_bypass: assert property (i_jog && q_r.jog_speed_setting <= q_r.min_freq_limit
                                 |-> tgt == q_r.jog_speed_setting)
    else $error("jog frequency was clamped by minimum");
  a_start_min: assert property (i_start && !i_jog && i_freq_cmd == FREQ_0HZ && !jz_hit
                                && q_r.min_freq_limit >= q_r.starting_freq_setting
                                |-> tgt == q_r.min_freq_limit)
    else $error("start alone did not target minimum");
  a_jump_sub: assert property (jz_hit && !i_jog && i_start
                               && jz_freq >= q_r.min_freq_limit
                               && jz_freq <= q_r.max_freq_limit
                               && jz_freq >= q_r.starting_freq_setting
                               |-> tgt == jz_freq)
    else $error("jump endpoint not used as target");
  a_stall_down: assert property (stall_active && !trip && !q_r.ol_stop
                                 && q_r.out_freq != FREQ_0HZ
                                 |=> q_r.out_freq < $past(q_r.out_freq))
    else $error("stall did not lower output");
  a_sel_off: assert property (q_r.stall_select_word[3:1] == 3'b111 && !drive_mode
                              |-> !stall_active)
    else $error("stall active with stall fully disabled");
  a_regen_off: assert property (drive_mode && i_regen |-> !stall_active && !o_fast_limit_en)
    else $error("stall or fast limit active in regeneration");
  a_nof_drive: assert property (q_r.stall_select_word == SEL_DRIVE_NOF |-> !o_fast_limit_en)
    else $error("fast limit active with selection 101");
  a_ol_cause: assert property ($rose(o_overload) |-> $past(stall_active))
    else $error("overload rose without stall action");
  a_trip_zero: assert property (trip |=> q_r.out_freq == FREQ_0HZ)
    else $error("output not tripped on stall fault");

  c_jump: cover property (jz_hit && i_start && !i_jog);
  c_overload: cover property ($rose(o_overload));
  c_below_min: cover property (stall_active && q_r.out_freq < q_r.min_freq_limit);
  c_regen: cover property (drive_mode && i_regen && i_current_over);

endmodule

// *** verilog/fdl_jump_zones.sv ***
module fdl_jump_zones
  import fdl_pkg::*;
#(
  parameter int ZONES = 3
) (
  input  wire logic [ZONES-1:0][15:0] i_zone_a,
  input  wire logic [ZONES-1:0][15:0] i_zone_b,
  input  wire logic [15:0]            i_req,
  output logic      [15:0]            o_freq,
  output logic                        o_hit
);

  // Either endpoint may be the low one; a 9999 endpoint disables the zone
  function automatic logic zone_hit(input fdl_freq_t a, input fdl_freq_t b,
                                    input fdl_freq_t f);
    fdl_freq_t lo;
    fdl_freq_t hi;
    lo = (a < b) ? a : b;
    hi = (a < b) ? b : a;
    return (a != FREQ_DISABLED) && (b != FREQ_DISABLED) && (f >= lo) && (f <= hi);
  endfunction

  // Lowest zone wins when zones overlap
  always_comb begin
    o_freq = i_req;
    o_hit  = 1'b0;
    for (int z = ZONES - 1; z >= 0; z--) begin
      if (zone_hit(i_zone_a[z], i_zone_b[z], i_req)) begin
        o_freq = i_zone_a[z];
        o_hit  = 1'b1;
      end
    end
  end

endmodule

// *** verilog/fdl_pkg.sv ***
package fdl_pkg;

  typedef logic [15:0] fdl_freq_t;

  // Frequencies are in steps of 0.1 Hz
  localparam fdl_freq_t FREQ_0HZ      = 16'h0000;
  localparam fdl_freq_t FREQ_1HZ      = 16'h000A;
  localparam fdl_freq_t FREQ_120HZ    = 16'h04B0;
  localparam fdl_freq_t FREQ_400HZ    = 16'h0FA0;
  localparam fdl_freq_t FREQ_DISABLED = 16'h270F;

  localparam fdl_freq_t MAX_RST   = FREQ_120HZ;
  localparam fdl_freq_t MIN_RST   = FREQ_0HZ;
  localparam fdl_freq_t HS_RST    = FREQ_120HZ;
  localparam fdl_freq_t JOG_RST   = 16'h0032;
  localparam fdl_freq_t START_RST = 16'h0005;
  localparam fdl_freq_t ACCEL_RST = 16'h0001;
  localparam logic [7:0] SEL_RST  = 8'h00;

  localparam logic [7:0] SEL_PLAIN_MAX = 8'h1F;
  localparam logic [7:0] SEL_DRIVE_FRL = 8'h64;
  localparam logic [7:0] SEL_DRIVE_NOF = 8'h65;
  localparam int SEL_BIT_FRL_OFF = 0;
  localparam int SEL_BIT_ACC_OFF = 1;
  localparam int SEL_BIT_OL_STOP = 4;

  localparam logic [7:0] ADDR_MAX       = 8'h00;
  localparam logic [7:0] ADDR_MIN       = 8'h04;
  localparam logic [7:0] ADDR_HS_MAX    = 8'h08;
  localparam logic [7:0] ADDR_JOG       = 8'h0C;
  localparam logic [7:0] ADDR_START     = 8'h10;
  localparam logic [7:0] ADDR_JUMP_BASE = 8'h14;
  localparam logic [7:0] ADDR_STALL_SEL = 8'h2C;
  localparam logic [7:0] ADDR_ACCEL     = 8'h30;
  localparam logic [7:0] ADDR_CTRL      = 8'h34;
  localparam logic [7:0] ADDR_STATUS    = 8'h38;
  localparam logic [7:0] REG_STRIDE     = 8'h04;
  localparam int JUMP_REGS = 6;

  localparam int CTRL_FAULT_CLR_BIT = 0;
  localparam int ST_OL_BIT    = 16;
  localparam int ST_FAULT_BIT = 17;
  localparam int ST_FRL_BIT   = 18;
  localparam int ST_STALL_BIT = 19;
  localparam int ST_STOP_BIT  = 20;

  localparam int CLK_HZ     = 100_000_000;
  localparam int OL_HOLD_MS = 100;
  localparam int OL_HOLD_CYC = OL_HOLD_MS * (CLK_HZ / 1000);
  localparam int TRIP_S     = 3;
  localparam int TRIP_CYC   = TRIP_S * CLK_HZ;

  typedef enum logic [1:0] {
    PH_ACCEL = 2'b00,
    PH_CONST = 2'b01,
    PH_DECEL = 2'b10
  } fdl_phase_t;

  typedef enum logic {
    OL_IDLE     = 1'b0,
    OL_ASSERTED = 1'b1
  } fdl_ol_state_t;

endpackage

// *** verilog/fdl_stall_monitor.sv ***
module fdl_stall_monitor
  import fdl_pkg::*;
#(
  parameter int HOLD_CYCLES = OL_HOLD_CYC,
  parameter int TRIP_CYCLES = TRIP_CYC
) (
  input  wire logic i_core_clk,
  input  wire logic i_rstn,
  input  wire logic i_stall_active,
  input  wire logic i_low_freq,
  input  wire logic i_fault_clr,
  output logic      o_overload,
  output logic      o_trip
);

  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam int TW = $clog2(TRIP_CYCLES + 1);

  typedef struct packed {
    fdl_ol_state_t ol;
    logic [HW-1:0] hold;
    logic [TW-1:0] trip_cnt;
    logic          fault;
  } fdl_stall_state_t;

  fdl_stall_state_t q_r;
  fdl_stall_state_t q_nxt;
  logic             trip_set;

  always_comb begin
    q_nxt    = q_r;
    trip_set = 1'b0;
    case (q_r.ol)
      OL_IDLE: begin
        if (i_stall_active) begin
          q_nxt.ol   = OL_ASSERTED;
          q_nxt.hold = HW'(HOLD_CYCLES - 1);
        end
      end
      OL_ASSERTED: begin
        // Minimum on-time runs out before current level may end the signal
        if (q_r.hold != '0) begin
          q_nxt.hold = q_r.hold - HW'(1);
        end else if (!i_stall_active) begin
          q_nxt.ol = OL_IDLE;
        end
      end
      default: q_nxt.ol = OL_IDLE;
    endcase
    if (i_stall_active && i_low_freq) begin
      if (q_r.trip_cnt == TW'(TRIP_CYCLES - 1)) begin
        trip_set = 1'b1;
      end else begin
        q_nxt.trip_cnt = q_r.trip_cnt + TW'(1);
      end
    end else begin
      q_nxt.trip_cnt = '0;
    end
    // Set wins over a clear in the same cycle
    q_nxt.fault = trip_set | (q_r.fault & ~i_fault_clr);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      q_r <= '{ol: OL_IDLE, hold: '0, trip_cnt: '0, fault: 1'b0};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_overload = (q_r.ol == OL_ASSERTED);
  assign o_trip     = q_r.fault;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  a_ol_min_hold: assert property (o_overload && q_r.hold != '0 |=> o_overload)
    else $error("overload dropped before minimum hold");
  a_ol_release: assert property (o_overload && q_r.hold == '0 && !i_stall_active
                                 |=> !o_overload)
    else $error("overload did not release after current fell");
  a_trip_time: assert property ($rose(o_trip) |-> $past(q_r.trip_cnt) == TW'(TRIP_CYCLES - 1))
    else $error("trip raised before full low-frequency time");
  c_trip: cover property ($rose(o_trip));

endmodule
